// *** design/eeprom_addr_decode.sv ***
// Purpose: Decodes a CPU address into the block's regions
// Assumes: Address is stable in the strobe cycle
// Notes:   Purely combinational
`timescale 1ns/100ps
`default_nettype none
module eeprom_addr_decode (
  input  wire logic [15:0] addr,      // CPU address
  output logic             is_array,  // Inside the 512-byte array
  output logic             is_nvr,    // Nonvolatile configuration byte
  output logic             is_ctrl,   // Control register
  output logic             is_shadow  // Configuration shadow
);
  import eeprom_ctl_pkg::*;
  // Region compares
  assign is_array  = (addr >= ARRAY_BASE) && (addr <= ARRAY_LAST);
  assign is_nvr    = (addr == NVR_ADDR);
  assign is_ctrl   = (addr == CTRL_ADDR);
  assign is_shadow = (addr == SHADOW_ADDR);
endmodule // eeprom_addr_decode
`default_nettype wire

// *** design/eeprom_ctl_pkg.sv ***
// Purpose: Shared constants for the EEPROM program/erase control block
// Assumes: 16-bit CPU addresses, 8-bit data
// Notes:   Control bit layout and control address are local choices
package eeprom_ctl_pkg;
  // Address map
  localparam logic [15:0] ARRAY_BASE  = 16'h0800;
  localparam logic [15:0] ARRAY_LAST  = 16'h09ff;
  localparam logic [15:0] CTRL_ADDR   = 16'hfe1a;
  localparam logic [15:0] NVR_ADDR    = 16'hfe1c;
  localparam logic [15:0] SHADOW_ADDR = 16'hfe1f;
  // Control register bit positions
  localparam int HV_BIT      = 0;
  localparam int LATCH_BIT   = 1;
  localparam int MODE_LO_BIT = 2;
  localparam int MODE_HI_BIT = 3;
  // Block index inside the array offset
  localparam int BLOCK_MSB = 8;
  localparam int BLOCK_LSB = 7;
  // Values after reset
  localparam logic [7:0] SHADOW_RESET = 8'h10;
  localparam logic [7:0] DATA_RESET   = 8'hff;
  localparam logic [7:0] RDATA_RESET  = 8'h00;
  localparam logic [8:0] ADDR_RESET   = 9'h000;
  // Operation codes carried by the two erase-mode bits
  typedef enum logic [1:0] {
    MODE_PROGRAM     = 2'h0,
    MODE_BYTE_ERASE  = 2'h1,
    MODE_BLOCK_ERASE = 2'h2,
    MODE_BULK_ERASE  = 2'h3
  } op_mode_t;
endpackage

// *** design/eeprom_program_erase_control.sv ***
// Purpose: Program/erase sequencer for a 512-byte on-chip EEPROM
// Assumes: Array and charge pump sit outside on the same clock
// Notes:   Registers reached over a plain strobe port
`timescale 1ns/100ps
`default_nettype none
module eeprom_program_erase_control (
  input  wire logic                     sys_clk,       // 20 MHz bus clock
  input  wire logic                     reset,         // Async, active high
  input  wire logic [15:0]              bus_addr,      // CPU address
  input  wire logic [7:0]               bus_wdata,     // CPU write data
  input  wire logic                     bus_wr,        // Write strobe
  input  wire logic                     bus_rd,        // Read strobe
  output logic      [7:0]               bus_rdata,     // Read data, next cycle
  input  wire logic [7:0]               array_rdata,   // Array byte at bus_addr
  input  wire logic [7:0]               nvr_byte,      // Stored config byte
  output logic                          pump_on,       // High voltage applied
  output eeprom_ctl_pkg::op_mode_t      op_mode,       // Operation to run
  output logic      [8:0]               tgt_addr,      // Captured array offset
  output logic                          tgt_nvr,       // Target is config byte
  output logic      [7:0]               tgt_data,      // Captured data
  output logic      [7:0]               config_shadow  // Volatile config copy
);
  import eeprom_ctl_pkg::*;

  // Address decode
  logic dec_array;
  logic dec_nvr;
  logic dec_ctrl;
  logic dec_shadow;
  eeprom_addr_decode u_dec (
    .addr      (bus_addr),
    .is_array  (dec_array),
    .is_nvr    (dec_nvr),
    .is_ctrl   (dec_ctrl),
    .is_shadow (dec_shadow)
  );

  // Control and capture state
  op_mode_t   mode_r;
  op_mode_t   mode_nxt;
  logic       latch_r;
  logic       latch_nxt;
  logic       hv_en_r;
  logic       hv_en_nxt;
  logic       captured_r;
  logic       captured_nxt;
  logic [8:0] tgt_addr_r;
  logic [8:0] tgt_addr_nxt;
  logic       tgt_nvr_r;
  logic       tgt_nvr_nxt;
  logic [7:0] tgt_data_r;
  logic [7:0] tgt_data_nxt;
  logic       pump_r;
  logic       pump_nxt;
  logic [7:0] shadow_r;
  logic [7:0] shadow_nxt;
  logic       load_pend_r;
  logic       load_pend_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;

  // Strobe qualifiers
  logic latch_wr;
  logic ctrl_wr;
  logic op_ok;
  logic [7:0] ctrl_view;

  // Config byte is a capture target as well as the array
  assign latch_wr = bus_wr && latch_r && (dec_array || dec_nvr);
  // While latched, control writes are held off until a capture
  assign ctrl_wr  = bus_wr && dec_ctrl && !(latch_r && !captured_r);

  // Protection and mode check on the captured target
  eeprom_protect_check u_prot (
    .mode    (mode_r),
    .tgt_nvr (tgt_nvr_r),
    .block   (tgt_addr_r[BLOCK_MSB:BLOCK_LSB]),
    .protect (shadow_r[3:0]),
    .op_ok   (op_ok)
  );

  // Control register as software reads it
  always_comb begin
    ctrl_view              = 8'h00;
    ctrl_view[HV_BIT]      = hv_en_r;
    ctrl_view[LATCH_BIT]   = latch_r;
    ctrl_view[MODE_LO_BIT] = mode_r[0];
    ctrl_view[MODE_HI_BIT] = mode_r[1];
  end

  // Next control state
  always_comb begin
    mode_nxt     = mode_r;
    latch_nxt    = latch_r;
    hv_en_nxt    = hv_en_r;
    captured_nxt = captured_r;
    tgt_addr_nxt = tgt_addr_r;
    tgt_nvr_nxt  = tgt_nvr_r;
    tgt_data_nxt = tgt_data_r;
    if (ctrl_wr) begin
      if (!hv_en_r) begin
        mode_nxt = op_mode_t'({bus_wdata[MODE_HI_BIT], bus_wdata[MODE_LO_BIT]});
        latch_nxt = bus_wdata[LATCH_BIT];
      end
      // Enable rises only once latched with a capture
      hv_en_nxt = bus_wdata[HV_BIT] && (hv_en_r || (latch_r && captured_r));
    end
    // Latch stays while enable is still set, even in a joint clear
    if (hv_en_r) begin
      latch_nxt = 1'b1;
    end
    if (latch_wr) begin
      // A later valid write replaces the earlier one
      captured_nxt = 1'b1;
      tgt_addr_nxt = bus_addr[8:0];
      tgt_nvr_nxt  = dec_nvr;
      tgt_data_nxt = bus_wdata;
    end else if (!latch_nxt) begin
      captured_nxt = 1'b0;
    end
  end

  // Voltage only while enabled and the target passes the check
  always_comb begin
    pump_nxt = hv_en_r && op_ok;
  end

  // Shadow load after reset release and on every config byte read
  always_comb begin
    shadow_nxt    = shadow_r;
    load_pend_nxt = 1'b0;
    if (load_pend_r || (bus_rd && dec_nvr)) begin
      shadow_nxt = nvr_byte;
    end
  end

  // Read data for the cycle after a read strobe
  always_comb begin
    rdata_nxt = RDATA_RESET;
    if (bus_rd) begin
      if (dec_array) begin
        rdata_nxt = latch_r ? tgt_data_r : array_rdata;
      end else if (dec_nvr) begin
        rdata_nxt = nvr_byte;
      end else if (dec_shadow) begin
        rdata_nxt = shadow_r;
      end else if (dec_ctrl) begin
        rdata_nxt = ctrl_view;
      end
    end
  end

  // Control and capture registers
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      mode_r     <= MODE_PROGRAM;
      latch_r    <= 1'b0;
      hv_en_r    <= 1'b0;
      captured_r <= 1'b0;
      tgt_addr_r <= ADDR_RESET;
      tgt_nvr_r  <= 1'b0;
      tgt_data_r <= DATA_RESET;
    end else begin
      mode_r     <= mode_nxt;
      latch_r    <= latch_nxt;
      hv_en_r    <= hv_en_nxt;
      captured_r <= captured_nxt;
      tgt_addr_r <= tgt_addr_nxt;
      tgt_nvr_r  <= tgt_nvr_nxt;
      tgt_data_r <= tgt_data_nxt;
    end
  end

  // Pump register; reset drops the voltage at once
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      pump_r <= 1'b0;
    end else begin
      pump_r <= pump_nxt;
    end
  end

  // Shadow register; the pending flag forces one load after reset
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      shadow_r    <= SHADOW_RESET;
      load_pend_r <= 1'b1;
    end else begin
      shadow_r    <= shadow_nxt;
      load_pend_r <= load_pend_nxt;
    end
  end

  // Read data register
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      rdata_r <= RDATA_RESET;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // Outputs straight from registers; the array sizes the erase from op_mode
  assign bus_rdata     = rdata_r;
  assign pump_on       = pump_r;
  assign op_mode       = mode_r;
  assign tgt_addr      = tgt_addr_r;
  assign tgt_nvr       = tgt_nvr_r;
  assign tgt_data      = tgt_data_r;
  assign config_shadow = shadow_r;

  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  latch_hold_a: assert property (hv_en_r |=> latch_r)
    else $error("latch dropped while enable set");
  joint_clear_a: assert property (
    ctrl_wr && hv_en_r && !bus_wdata[HV_BIT] && !bus_wdata[LATCH_BIT]
    |=> !hv_en_r && latch_r)
    else $error("joint clear did not keep latch");
  hv_gate_a: assert property ($rose(hv_en_r) |-> $past(latch_r && captured_r))
    else $error("enable rose without capture");
  mode_freeze_a: assert property (hv_en_r |=> mode_r == $past(mode_r))
    else $error("mode changed while enabled");
  capture_a: assert property (
    bus_wr && latch_r && dec_array
    |=> captured_r && tgt_data_r == $past(bus_wdata) && tgt_addr_r == $past(bus_addr[8:0]))
    else $error("valid write not captured");
  no_capture_a: assert property (bus_wr && !latch_r |=> $stable(tgt_data_r))
    else $error("write captured without latch");
  wait_capture_a: assert property (
    bus_wr && dec_ctrl && latch_r && !captured_r |=> !hv_en_r && $stable(mode_r))
    else $error("control write accepted before capture");
  readback_a: assert property (
    bus_rd && latch_r && dec_array |=> bus_rdata == $past(tgt_data_r))
    else $error("latched read returned array data");
  shadow_load_a: assert property (bus_rd && dec_nvr |=> shadow_r == $past(nvr_byte))
    else $error("shadow not reloaded on config read");
  pump_gate_a: assert property (
    pump_on |-> $past(hv_en_r) && $past(op_ok))
    else $error("voltage without enable or permission");
  bulk_prot_a: assert property (
    hv_en_r && mode_r == MODE_BULK_ERASE && (|shadow_r[3:0]) |=> !pump_on)
    else $error("bulk erase with protection active");

  // Voltage, protection and capture targets
  pump_on_a: assert property (hv_en_r && op_ok |=> pump_on)
    else $error("voltage missing while enabled and allowed");
  pump_off_a: assert property (!hv_en_r |=> !pump_on)
    else $error("voltage left on after enable cleared");
  wide_nvr_a: assert property (
    tgt_nvr_r && (mode_r == MODE_BLOCK_ERASE || mode_r == MODE_BULK_ERASE) |-> !op_ok)
    else $error("wide erase allowed on config byte");
  block_prot_a: assert property (
    !tgt_nvr_r && shadow_r[tgt_addr_r[BLOCK_MSB:BLOCK_LSB]] |-> !op_ok)
    else $error("protected block allowed voltage");
  nvr_access_a: assert property (
    tgt_nvr_r && (mode_r == MODE_PROGRAM || mode_r == MODE_BYTE_ERASE) |-> op_ok)
    else $error("config byte refused for byte operation");
  enable_refuse_a: assert property (ctrl_wr && !latch_r && !hv_en_r |=> !hv_en_r)
    else $error("enable set without latch");
  reset_load_a: assert property ($fell(load_pend_r) |-> config_shadow == $past(nvr_byte))
    else $error("shadow not loaded after reset");
  stray_write_a: assert property (
    bus_wr && latch_r && !dec_array && !dec_nvr |=> $stable(tgt_addr_r) && $stable(tgt_data_r))
    else $error("write outside array captured");
  nvr_capture_a: assert property (bus_wr && latch_r && dec_nvr |=> tgt_nvr_r)
    else $error("config byte write not captured");

  program_c: cover property (hv_en_r && mode_r == MODE_PROGRAM ##1 pump_on);
  block_erase_c: cover property (hv_en_r && mode_r == MODE_BLOCK_ERASE ##1 pump_on);
  refused_c: cover property (hv_en_r && !op_ok ##1 !pump_on);
  joint_clear_c: cover property (
    ctrl_wr && hv_en_r && !bus_wdata[HV_BIT] && !bus_wdata[LATCH_BIT]);
  bulk_erase_c: cover property (hv_en_r && mode_r == MODE_BULK_ERASE ##1 pump_on);
endmodule // eeprom_program_erase_control
`default_nettype wire

// *** design/eeprom_protect_check.sv ***
// Purpose: Decides whether a captured target may receive high voltage
// Assumes: Inputs come from registers of the control block
// Notes:   Purely combinational
`timescale 1ns/100ps
`default_nettype none
module eeprom_protect_check (
  input  wire eeprom_ctl_pkg::op_mode_t mode,     // Selected operation
  input  wire logic                     tgt_nvr,  // Target is config byte
  input  wire logic [1:0]               block,    // Target block index
  input  wire logic [3:0]               protect,  // Block protect bits
  output logic                          op_ok     // Voltage may be applied
);
  import eeprom_ctl_pkg::*;
  logic blk_prot;
  assign blk_prot = protect[block];
  // Protection overrides every mode for array targets; wide erases never touch the config byte
  always_comb begin
    unique case (mode)
      MODE_PROGRAM,
      MODE_BYTE_ERASE:  op_ok = tgt_nvr || !blk_prot;
      MODE_BLOCK_ERASE: op_ok = !tgt_nvr && !blk_prot;
      MODE_BULK_ERASE:  op_ok = !tgt_nvr && !(|protect);
    endcase
  end
endmodule // eeprom_protect_check
`default_nettype wire

// *** sim/eeprom_array_model.sv ***
// Purpose: Array and charge pump model beside the EEPROM control block
// Assumes: Same bus clock as the control block
// Notes:   Applies the selected operation each cycle the pump runs
`timescale 1ns/100ps
`default_nettype none
module eeprom_array_model (
  input  wire logic                     sys_clk,     // Bus clock
  input  wire logic [15:0]              bus_addr,    // CPU address
  input  wire logic                     pump_on,     // High voltage on
  input  wire eeprom_ctl_pkg::op_mode_t op_mode,     // Operation
  input  wire logic [8:0]               tgt_addr,    // Target offset
  input  wire logic                     tgt_nvr,     // Target is config byte
  input  wire logic [7:0]               tgt_data,    // Data to program
  output logic      [7:0]               array_rdata, // Byte at bus_addr
  output logic      [7:0]               nvr_byte     // Config byte
);
  import eeprom_ctl_pkg::*;
  logic [7:0] mem [512];
  // Delivered erased and unprotected
  initial begin
    foreach (mem[i]) mem[i] = 8'hff;
    nvr_byte = 8'h10;
  end
  assign array_rdata = mem[bus_addr[8:0]];
  // Only the pump's voltage changes cells; wide erases skip the config byte
  always @(posedge sys_clk) begin
    if (pump_on && tgt_nvr) begin
      if (op_mode == MODE_PROGRAM) nvr_byte <= nvr_byte & tgt_data;
      else if (op_mode == MODE_BYTE_ERASE) nvr_byte <= 8'hff;
    end else if (pump_on) begin
      case (op_mode)
        MODE_PROGRAM:    mem[tgt_addr] <= mem[tgt_addr] & tgt_data;
        MODE_BYTE_ERASE: mem[tgt_addr] <= 8'hff;
        MODE_BLOCK_ERASE: for (int i = 0; i < 128; i++)
          mem[{tgt_addr[8:7], 7'(i)}] <= 8'hff;
        default: foreach (mem[i]) mem[i] <= 8'hff;
      endcase
    end
  end
endmodule // eeprom_array_model
`default_nettype wire

// *** sim/tb_eeprom_program_erase_control.sv ***
// Purpose: Self-checking bench for the EEPROM program/erase control block
// Assumes: Array model on the far side, bus driven by tasks
// Notes:   Rows run full sequences; hand tests cover interlocks
`timescale 1ns/100ps
`default_nettype none
module tb_eeprom_program_erase_control;
  import eeprom_ctl_pkg::*;
  typedef struct packed {
    logic [1:0] mode; logic [15:0] wa; logic [7:0] wd;
    logic [15:0] ra; logic [7:0] exp; logic pump;
  } row_t;
  localparam row_t ROWS [13] = '{
    '{2'h0, 16'h0810, 8'h5a, 16'h0810, 8'h5a, 1'b1},
    '{2'h0, 16'h0810, 8'h0f, 16'h0810, 8'h0a, 1'b1},
    '{2'h1, 16'h0810, 8'h00, 16'h0810, 8'hff, 1'b1},
    '{2'h0, 16'h0900, 8'h00, 16'h0900, 8'h00, 1'b1},
    '{2'h2, 16'h0901, 8'h00, 16'h0900, 8'hff, 1'b1},
    '{2'h0, 16'h0800, 8'h11, 16'h0800, 8'h11, 1'b1},
    '{2'h3, 16'h09ff, 8'h00, 16'h0800, 8'hff, 1'b1},
    '{2'h0, 16'h0810, 8'h00, 16'h0810, 8'h00, 1'b1},
    '{2'h1, NVR_ADDR, 8'h00, NVR_ADDR, 8'hff, 1'b1},
    '{2'h1, 16'h0810, 8'hff, 16'h0810, 8'h00, 1'b0},
    '{2'h3, 16'h0800, 8'h00, 16'h0810, 8'h00, 1'b0},
    '{2'h2, NVR_ADDR, 8'h00, NVR_ADDR, 8'hff, 1'b0},
    '{2'h0, NVR_ADDR, 8'h10, NVR_ADDR, 8'h10, 1'b1}};
  logic sys_clk, reset, bus_wr, bus_rd, pump_on, tgt_nvr;
  logic [15:0] bus_addr;
  logic [7:0] bus_wdata, bus_rdata, array_rdata, nvr_byte, tgt_data, config_shadow;
  logic [8:0] tgt_addr;
  op_mode_t op_mode;
  int n_mismatch = 0;
  int n_checks = 0;
  eeprom_program_erase_control i_dut (.sys_clk(sys_clk), .reset(reset),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_rdata(bus_rdata), .array_rdata(array_rdata), .nvr_byte(nvr_byte),
    .pump_on(pump_on), .op_mode(op_mode), .tgt_addr(tgt_addr), .tgt_nvr(tgt_nvr),
    .tgt_data(tgt_data), .config_shadow(config_shadow));
  eeprom_array_model i_array (.sys_clk(sys_clk), .bus_addr(bus_addr), .pump_on(pump_on),
    .op_mode(op_mode), .tgt_addr(tgt_addr), .tgt_nvr(tgt_nvr), .tgt_data(tgt_data),
    .array_rdata(array_rdata), .nvr_byte(nvr_byte));
  // Bus clock, 50 ns period
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  // Compare and count
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      n_mismatch++;
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge sys_clk);
    bus_wr <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input string nm, input logic [7:0] e);
    @(posedge sys_clk);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge sys_clk);
    bus_rd <= 1'b0;
    @(negedge sys_clk);
    chk(nm, e, bus_rdata);
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // One full latch, write, voltage, release sequence
  task automatic run_op(input row_t r);
    wr(CTRL_ADDR, {4'h0, r.mode, 2'b10});
    wr(r.wa, r.wd);
    rd(ARRAY_LAST, "latched read", r.wd);
    chk("tgt nvr", {7'h0, r.wa == NVR_ADDR}, {7'h0, tgt_nvr});
    wr(CTRL_ADDR, {4'h0, r.mode, 2'b11});
    wr(CTRL_ADDR, {4'h0, ~r.mode, 2'b11});
    cyc(2);
    chk("pump on", {7'h0, r.pump}, {7'h0, pump_on});
    chk("mode held", {6'h0, r.mode}, {6'h0, op_mode});
    wr(CTRL_ADDR, 8'h00);
    cyc(3);
    chk("pump off", 8'h00, {7'h0, pump_on});
    rd(CTRL_ADDR, "ctrl kept", {4'h0, r.mode, 2'b10});
    wr(CTRL_ADDR, 8'h00);
    rd(r.ra, "array byte", r.exp);
  endtask
  // Watchdog against a hung run
  initial begin
    repeat (30000) @(posedge sys_clk);
    n_mismatch++;
    final_report();
  end
  // Main sequence
  initial begin
    reset = 1'b1;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    bus_addr = 16'h0;
    bus_wdata = 8'h0;
    repeat (10) @(posedge sys_clk);
    reset <= 1'b0;
    foreach (ROWS[i]) run_op(ROWS[i]);
    $display("test rows done");
    @(posedge sys_clk);
    reset <= 1'b1;
    cyc(2);
    chk("tgt data reset", 8'hff, tgt_data);
    @(posedge sys_clk);
    reset <= 1'b0;
    rd(CTRL_ADDR, "ctrl reset", 8'h00);
    rd(SHADOW_ADDR, "shadow", 8'h10);
    chk("shadow out", 8'h10, config_shadow);
    $display("test reset done");
    wr(CTRL_ADDR, 8'h02);
    wr(CTRL_ADDR, 8'h0f);
    wr(16'h0a00, 8'h77);
    cyc(3);
    chk("pump refused", 8'h00, {7'h0, pump_on});
    rd(CTRL_ADDR, "ctrl held", 8'h02);
    wr(16'h0820, 8'h33);
    wr(16'h0830, 8'h44);
    cyc(0);
    chk("tgt addr", 8'h30, tgt_addr[7:0]);
    chk("tgt data", 8'h44, tgt_data);
    rd(16'h0800, "latched read", 8'h44);
    wr(CTRL_ADDR, 8'h00);
    rd(CTRL_ADDR, "ctrl clear", 8'h00);
    $display("test capture done");
    wr(16'h0a00, 8'h00);
    wr(CTRL_ADDR, 8'h01);
    cyc(3);
    chk("pump no latch", 8'h00, {7'h0, pump_on});
    rd(CTRL_ADDR, "ctrl no latch", 8'h00);
    $display("test enable refusal done");
    final_report();
  end
endmodule // tb_eeprom_program_erase_control
`default_nettype wire
